// ### rtl/sdc_controller.sv
// Controller end: divides its clock into the link clock and paces commands
`timescale 1ns/1ps
module sdc_controller (
  input wire logic clk,
  input wire logic rst,
  sdc_link_if.ctrl link,
  input wire logic req_valid,
  input wire logic [3:0] req_cmd,
  input wire logic [1:0] req_bank,
  input wire logic [11:0] req_addr,
  input wire logic req_mask,
  input wire logic req_cke,
  output logic req_ready
);
  // ----------------------------------------
  // Link clock divider and command pacing
  // ----------------------------------------
  // Pins change on the falling link edge so the device samples mid-period
  logic [3:0] div;
  logic ck;
  logic [7:0] wait_cnt;
  logic [3:0] cmd_q;
  logic busy;
  logic [3:0] next_div;
  logic next_ck;
  logic [7:0] next_wait;
  logic [3:0] next_cmd;
  logic next_busy;
  logic next_cke;
  logic [1:0] next_bank;
  logic [11:0] next_addr;
  logic next_mask;
  logic fall;

  function automatic logic [7:0] sdc_gap(input logic [3:0] c, input logic cke_now,
                                         input logic cke_new);
    if (!cke_now && cke_new) begin
      return sdc_pkg::SELF_REFRESH_EXIT_TIME;
    end
    case (c)
      sdc_pkg::CMD_REF: return sdc_pkg::REFRESH_CYCLE_TIME;
      sdc_pkg::CMD_PRE: return sdc_pkg::PRECHARGE_PERIOD;
      sdc_pkg::CMD_ACT: return sdc_pkg::ACTIVATE_TO_COLUMN_DELAY;
      sdc_pkg::CMD_MRS: return {4'h0, sdc_pkg::MRS_GAP};
      default: return 8'h01;
    endcase
  endfunction : sdc_gap

  assign fall = (div == sdc_pkg::LINK_DIV_HALF - 4'h1) && ck;
  assign link.ck = ck;

  always_comb begin
    next_div = div + 4'h1;
    next_ck = ck;
    if (div == sdc_pkg::LINK_DIV_HALF - 4'h1) begin
      next_div = 4'h0;
      next_ck = !ck;
    end
    next_wait = wait_cnt;
    next_cmd = sdc_pkg::CMD_NOP;
    next_busy = busy;
    next_cke = link.cke;
    next_bank = link.bank_select;
    next_addr = link.addr;
    next_mask = link.write_data_mask;
    if (fall) begin
      next_cmd = sdc_pkg::CMD_NOP;
      if (wait_cnt != 8'h00) begin
        next_wait = wait_cnt - 8'h01;
      end else begin
        next_busy = 1'b0;
      end
      if (req_valid && !busy) begin
        next_cmd = req_cmd;
        next_cke = req_cke;
        next_bank = req_bank;
        next_addr = req_addr;
        next_mask = req_mask;
        next_wait = sdc_gap(req_cmd, link.cke, req_cke);
        next_busy = 1'b1;
      end
    end else begin
      next_cmd = cmd_q;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div <= 4'h0;
      ck <= 1'b0;
      wait_cnt <= 8'h00;
      cmd_q <= sdc_pkg::CMD_NOP;
      busy <= 1'b0;
      link.cke <= 1'b0;
      link.cs_n <= 1'b1;
      link.ras_n <= 1'b1;
      link.cas_n <= 1'b1;
      link.we_n <= 1'b1;
      link.bank_select <= 2'h0;
      link.addr <= sdc_pkg::ADDR_RESET;
      link.write_data_mask <= 1'b0;
      req_ready <= 1'b0;
    end else begin
      div <= next_div;
      ck <= next_ck;
      wait_cnt <= next_wait;
      cmd_q <= next_cmd;
      busy <= next_busy;
      link.cke <= next_cke;
      {link.cs_n, link.ras_n, link.cas_n, link.we_n} <= next_cmd;
      link.bank_select <= next_bank;
      link.addr <= next_addr;
      link.write_data_mask <= next_mask;
      req_ready <= !next_busy;
    end
  end
endmodule : sdc_controller

// ### rtl/sdc_device.sv
// Device end: command decode, bank state, refresh and power-down control
// Functional notes
// - Auto refresh: cs,ras,cas low, cke,we high
// - Controller precharges all banks before refresh
// - Refresh row comes from internal counter
// - Refresh leaves all banks idle
// - Controller waits refresh cycle time afterwards
// - Self refresh entry: like refresh, cke low
// - Self refresh ignores all but clock enable
// - Internal clock gated during self refresh
// - Controller exits self refresh with stable clock
// - Write after activate waits column delay
// - Power-down follows clock enable; receivers gated
// - Controller idles banks, raises cke early
// - Controller leaves power-down before retention expires
// - Same-bank write at 3-4 drops auto-precharge
// - Same-bank read: 4-5 masked, 6 free
// - Other bank: writes from 3, reads 6
// - Command encoding of mrs/act/rd/wr/bst/pre
// - Address bit ten selects auto-precharge
// - Precharge with bit ten selects all banks
// - Mode set only idle, then two-cycle gap
// - Bank select picks bank A to D
`timescale 1ns/1ps
module sdc_device (
  sdc_link_if.dev link,
  input wire logic rst,
  output logic [3:0] bank_active,
  output logic powered_down,
  output logic in_self_refresh,
  output logic clk_gated,
  output logic [11:0] refresh_row,
  output logic refresh_pulse,
  output logic [9:0] column,
  output logic col_auto_precharge,
  output logic col_write,
  output logic col_valid,
  output logic illegal_cmd
);
  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic cke_prev;
  logic [3:0] cmd;
  logic [3:0] wap_cnt;
  logic [1:0] wap_bank;
  logic [3:0] mrs_cnt;
  sdc_pkg::sdc_bank_t bank_st [4];
  sdc_pkg::sdc_pwr_t pwr;
  logic next_cke_prev;
  logic [3:0] next_wap_cnt;
  logic [1:0] next_wap_bank;
  logic [3:0] next_mrs_cnt;
  sdc_pkg::sdc_bank_t next_bank_st [4];
  sdc_pkg::sdc_pwr_t next_pwr;
  logic [11:0] next_refresh_row;
  logic next_refresh_pulse;
  logic [9:0] next_column;
  logic next_col_ap;
  logic next_col_write;
  logic next_col_valid;
  logic next_illegal;
  logic all_idle;
  logic same;
  logic run_q;
  logic dev_rst;

  function automatic logic [3:0] sdc_decode(input logic cs_n, input logic ras_n,
                                            input logic cas_n, input logic we_n);
    if (cs_n) begin
      return sdc_pkg::CMD_DESEL;
    end
    return {1'b0, ras_n, cas_n, we_n};
  endfunction : sdc_decode

  assign cmd = sdc_decode(link.cs_n, link.ras_n, link.cas_n, link.we_n);

  // Release retimed onto the link clock; assertion stays immediate to avoid recovery races
  sdc_sync #(.W(1)) u_rst_sync (.clk(link.ck), .rst(rst), .d(1'b1), .q(run_q));
  assign dev_rst = rst | !run_q;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_cke_prev = link.cke;
    next_wap_cnt = wap_cnt;
    next_wap_bank = wap_bank;
    next_mrs_cnt = mrs_cnt;
    next_bank_st = bank_st;
    next_pwr = pwr;
    next_refresh_row = refresh_row;
    next_refresh_pulse = 1'b0;
    next_column = column;
    next_col_ap = col_auto_precharge;
    next_col_write = col_write;
    next_col_valid = 1'b0;
    next_illegal = 1'b0;
    all_idle = 1'b1;
    same = (link.bank_select == wap_bank);
    for (int b = 0; b < sdc_pkg::BANKS; b++) begin
      if (bank_st[b] != sdc_pkg::SDC_IDLE) begin
        all_idle = 1'b0;
      end
    end
    if (wap_cnt != 4'h0) begin
      next_wap_cnt = wap_cnt + 4'h1;
      if (wap_cnt == sdc_pkg::WAP_END) begin
        next_wap_cnt = 4'h0;
        next_bank_st[wap_bank] = sdc_pkg::SDC_IDLE;
      end
    end
    if (mrs_cnt != 4'h0) begin
      next_mrs_cnt = mrs_cnt - 4'h1;
    end
    case (pwr)
      sdc_pkg::SDC_SELF: begin
        // Only cke is looked at here; the rest of the pins are dead
        if (link.cke) begin
          next_pwr = sdc_pkg::SDC_RUN;
        end
      end
      sdc_pkg::SDC_PDOWN: begin
        if (link.cke) begin
          next_pwr = sdc_pkg::SDC_RUN;
        end
      end
      sdc_pkg::SDC_RUN: begin
        if (cke_prev && !link.cke) begin
          if (cmd == sdc_pkg::CMD_REF) begin
            next_pwr = sdc_pkg::SDC_SELF;
            next_illegal = !all_idle;
          end else begin
            next_pwr = sdc_pkg::SDC_PDOWN;
          end
        end else if (cke_prev) begin
          if (cmd != sdc_pkg::CMD_DESEL && cmd != sdc_pkg::CMD_NOP && mrs_cnt != 4'h0) begin
            next_illegal = 1'b1;
          end
          case (cmd)
            sdc_pkg::CMD_MRS: begin
              next_illegal = next_illegal | !all_idle;
              next_mrs_cnt = sdc_pkg::MRS_GAP - 4'h1;
            end
            sdc_pkg::CMD_REF: begin
              next_illegal = next_illegal | !all_idle;
              next_refresh_row = refresh_row + 12'h001;
              next_refresh_pulse = 1'b1;
              for (int b = 0; b < sdc_pkg::BANKS; b++) begin
                next_bank_st[b] = sdc_pkg::SDC_IDLE;
              end
            end
            sdc_pkg::CMD_ACT: begin
              if (bank_st[link.bank_select] != sdc_pkg::SDC_IDLE) begin
                next_illegal = 1'b1;
              end else if (wap_cnt != 4'h0 && same) begin
                next_illegal = 1'b1;
              end else begin
                next_bank_st[link.bank_select] = sdc_pkg::SDC_ACTIVE;
              end
            end
            sdc_pkg::CMD_PRE: begin
              if (wap_cnt != 4'h0 && (same || link.addr[sdc_pkg::AP_BIT])) begin
                next_illegal = 1'b1;
              end else if (link.addr[sdc_pkg::AP_BIT]) begin
                for (int b = 0; b < sdc_pkg::BANKS; b++) begin
                  next_bank_st[b] = sdc_pkg::SDC_IDLE;
                end
              end else begin
                next_bank_st[link.bank_select] = sdc_pkg::SDC_IDLE;
              end
            end
            sdc_pkg::CMD_WR, sdc_pkg::CMD_RD: begin
              next_column = link.addr[sdc_pkg::COL_W-1:0];
              next_col_ap = link.addr[sdc_pkg::AP_BIT];
              next_col_write = (cmd == sdc_pkg::CMD_WR);
              next_col_valid = 1'b1;
              if (wap_cnt != 4'h0 && same) begin
                if (cmd == sdc_pkg::CMD_WR) begin
                  if (wap_cnt <= sdc_pkg::WAP_WR_LAST) begin
                    next_wap_cnt = 4'h0;
                    next_bank_st[wap_bank] = sdc_pkg::SDC_ACTIVE;
                  end else begin
                    next_illegal = 1'b1;
                  end
                end else if (wap_cnt >= sdc_pkg::WAP_RD_MASK_FIRST &&
                             wap_cnt <= sdc_pkg::WAP_RD_FREE) begin
                  // Cycles four and five need masked write data
                  next_illegal = next_illegal | ((wap_cnt <= sdc_pkg::WAP_RD_MASK_LAST) &&
                                 !link.write_data_mask);
                  next_wap_cnt = 4'h0;
                  next_bank_st[wap_bank] = sdc_pkg::SDC_ACTIVE;
                end else begin
                  next_illegal = 1'b1;
                end
              end else if (wap_cnt != 4'h0 && cmd == sdc_pkg::CMD_RD &&
                           wap_cnt < sdc_pkg::WAP_OTHER_RD) begin
                next_illegal = 1'b1;
              end else if (bank_st[link.bank_select] != sdc_pkg::SDC_ACTIVE) begin
                next_illegal = 1'b1;
              end
              if (!next_illegal && link.addr[sdc_pkg::AP_BIT] && cmd == sdc_pkg::CMD_WR) begin
                next_wap_cnt = sdc_pkg::WAP_OTHER_ANY - 4'h2;
                next_wap_bank = link.bank_select;
                next_bank_st[link.bank_select] = sdc_pkg::SDC_WAP;
              end else if (!next_illegal && link.addr[sdc_pkg::AP_BIT]) begin
                next_bank_st[link.bank_select] = sdc_pkg::SDC_IDLE;
              end
            end
            default: begin
            end
          endcase
        end
      end
      default: begin
        next_pwr = sdc_pkg::SDC_RUN;
      end
    endcase
  end

  // ----------------------------------------
  // State registers on the link clock
  // ----------------------------------------
  // No reset pin on the part; rst models power-up only
  always_ff @(posedge link.ck or posedge dev_rst) begin
    if (dev_rst) begin
      cke_prev <= 1'b0;
      wap_cnt <= 4'h0;
      wap_bank <= 2'h0;
      mrs_cnt <= 4'h0;
      pwr <= sdc_pkg::SDC_RUN;
      bank_st <= '{default: sdc_pkg::SDC_IDLE};
      refresh_row <= sdc_pkg::ADDR_RESET;
      refresh_pulse <= 1'b0;
      column <= 10'h000;
      col_auto_precharge <= 1'b0;
      col_write <= 1'b0;
      col_valid <= 1'b0;
      illegal_cmd <= 1'b0;
      bank_active <= 4'h0;
      powered_down <= 1'b0;
      in_self_refresh <= 1'b0;
      clk_gated <= 1'b0;
    end else begin
      cke_prev <= next_cke_prev;
      wap_cnt <= next_wap_cnt;
      wap_bank <= next_wap_bank;
      mrs_cnt <= next_mrs_cnt;
      pwr <= next_pwr;
      bank_st <= next_bank_st;
      refresh_row <= next_refresh_row;
      refresh_pulse <= next_refresh_pulse;
      column <= next_column;
      col_auto_precharge <= next_col_ap;
      col_write <= next_col_write;
      col_valid <= next_col_valid;
      illegal_cmd <= next_illegal;
      for (int b = 0; b < sdc_pkg::BANKS; b++) begin
        bank_active[b] <= (next_bank_st[b] != sdc_pkg::SDC_IDLE);
      end
      powered_down <= (next_pwr == sdc_pkg::SDC_PDOWN);
      in_self_refresh <= (next_pwr == sdc_pkg::SDC_SELF);
      clk_gated <= (next_pwr == sdc_pkg::SDC_SELF);
    end
  end
endmodule : sdc_device

// ### rtl/sdc_link_if.sv
// Interface: command pins between the memory controller and the device
`timescale 1ns/1ps
interface sdc_link_if;
  logic ck;
  logic cke;
  logic cs_n;
  logic ras_n;
  logic cas_n;
  logic we_n;
  logic [1:0] bank_select;
  logic [11:0] addr;
  logic write_data_mask;
  modport ctrl (output ck, output cke, output cs_n, output ras_n, output cas_n, output we_n,
    output bank_select, output addr, output write_data_mask);
  modport dev (input ck, input cke, input cs_n, input ras_n, input cas_n, input we_n,
    input bank_select, input addr, input write_data_mask);
endinterface : sdc_link_if

// ### rtl/sdc_pkg.sv
// Package: command codes, bank states and timing counts for the refresh/power-down command link
package sdc_pkg;
  localparam int BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ADDR_W = 12;
  localparam int COL_W = 10;
  localparam int AP_BIT = 10;
  localparam int ROW_CNT_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 12'h000;
  // Command nibble {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_BST = 4'h6;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_DESEL = 4'h8;
  // Write with auto-precharge window, burst length four, cycles after the command
  localparam logic [3:0] WAP_WR_FIRST = 4'h3;
  localparam logic [3:0] WAP_WR_LAST = 4'h4;
  localparam logic [3:0] WAP_RD_MASK_FIRST = 4'h4;
  localparam logic [3:0] WAP_RD_MASK_LAST = 4'h5;
  localparam logic [3:0] WAP_RD_FREE = 4'h6;
  localparam logic [3:0] WAP_END = 4'h8;
  localparam logic [3:0] WAP_OTHER_RD = 4'h6;
  localparam logic [3:0] WAP_OTHER_ANY = 4'h3;
  localparam logic [3:0] MRS_GAP = 4'h2;
  // Host timing, in link cycles; LINK_DIV_HALF is in controller clock cycles
  localparam logic [7:0] PRECHARGE_PERIOD = 8'h03;
  localparam logic [7:0] REFRESH_CYCLE_TIME = 8'h0A;
  localparam logic [7:0] SELF_REFRESH_EXIT_TIME = 8'h14;
  localparam logic [7:0] ACTIVATE_TO_COLUMN_DELAY = 8'h03;
  localparam logic [7:0] PD_EXIT_CYCLES = 8'h02;
  localparam logic [3:0] LINK_DIV_HALF = 4'h2;
  typedef enum logic [1:0] {SDC_IDLE, SDC_ACTIVE, SDC_WAP} sdc_bank_t;
  typedef enum logic [1:0] {SDC_RUN, SDC_SELF, SDC_PDOWN} sdc_pwr_t;
endpackage : sdc_pkg

// ### rtl/sdc_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
module sdc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;
  always_comb begin
    next_meta = d;
    next_q = meta;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : sdc_sync

// ### verification/sdc_link_monitor.sv
// Checker: pacing relations that the controller keeps on the link pins
`timescale 1ns/1ps
module sdc_link_monitor (
  input wire logic ck,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic ras_n,
  input wire logic cas_n,
  input wire logic we_n,
  input wire logic [1:0] bank_select,
  input wire logic [11:0] addr,
  input wire logic write_data_mask
);
  // ----------------------------------------
  // Helper state
  // ----------------------------------------
  logic [3:0] cmd;
  logic idle;
  logic in_sr;
  logic [4:0] since_ref;
  logic [4:0] since_exit;
  assign cmd = {cs_n, ras_n, cas_n, we_n};
  assign idle = cs_n | (cmd == sdc_pkg::CMD_NOP);
  // Saturating counts, so an early command after reset never trips a check
  always_ff @(posedge ck or posedge rst) begin
    if (rst) begin
      in_sr <= 1'b0;
      since_ref <= 5'h1F;
      since_exit <= 5'h1F;
    end else begin
      in_sr <= cke ? 1'b0 : (in_sr | (cmd == sdc_pkg::CMD_REF));
      since_ref <= (cke && cmd == sdc_pkg::CMD_REF) ? 5'h00 :
        ((since_ref == 5'h1F) ? 5'h1F : since_ref + 5'h01);
      since_exit <= (in_sr && cke) ? 5'h00 :
        ((since_exit == 5'h1F) ? 5'h1F : since_exit + 5'h01);
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge ck); endclocking
  default disable iff (rst);
  sequence s_nop_run;
    idle [*8];
  endsequence
  sequence s_sr_exit;
    in_sr && cke;
  endsequence
  chk_refresh_gap: assert property (cke && (cmd == sdc_pkg::CMD_REF ||
    cmd == sdc_pkg::CMD_ACT) |-> since_ref >= 5'h09)
    else $error("refresh or activate too soon after refresh");
  chk_ref_then_nop: assert property (cke && cmd == sdc_pkg::CMD_REF |=> idle)
    else $error("refresh not followed by idle pins");
  chk_mrs_gap: assert property (cmd == sdc_pkg::CMD_MRS |=> idle)
    else $error("mode set not followed by idle pins");
  chk_act_to_write: assert property (cmd == sdc_pkg::CMD_ACT |=>
    (cmd != sdc_pkg::CMD_WR) [*2])
    else $error("write too soon after activate");
  chk_pre_to_ref: assert property (cmd == sdc_pkg::CMD_PRE |=>
    (cmd != sdc_pkg::CMD_REF) [*2])
    else $error("refresh too soon after precharge");
  chk_cke_before_act: assert property (cke && cmd == sdc_pkg::CMD_ACT |-> $past(cke))
    else $error("clock enable raised with activate");
  chk_exit_nop_run: assert property (s_sr_exit |-> s_nop_run)
    else $error("command during self refresh exit");
  chk_exit_gap: assert property (cke && !idle |-> since_exit >= 5'h13)
    else $error("command before self refresh exit time");
endmodule : sdc_link_monitor

// ### verification/sdram_refresh_powerdown_cmd_bench.sv
// Bench: controller and device joined over the link, checked end to end
`timescale 1ns/1ps
module sdram_refresh_powerdown_cmd_bench;
  typedef struct packed {logic [3:0] c; logic [1:0] b; logic [11:0] a;
    logic [3:0] act; logic col; logic rf;} sdc_row_t;
  typedef struct packed {logic rd; logic same; logic m; logic [3:0] dd;} sdc_wap_t;
  logic clk;
  logic rst;
  logic req_valid;
  logic [3:0] req_cmd;
  logic [1:0] req_bank;
  logic [11:0] req_addr;
  logic req_mask;
  logic req_cke;
  logic req_ready;
  logic [3:0] bank_active;
  logic powered_down, in_self_refresh, clk_gated, refresh_pulse;
  logic [11:0] refresh_row;
  logic [9:0] column;
  logic col_auto_precharge, col_write, col_valid, illegal_cmd;
  int fails = 0;
  int num_checks = 0;
  int n_col = 0, n_ref = 0, n_ill = 0, n_cmd = 0, lcyc = 0, cmd_cyc = 0;
  int i0, c0, f0, t0, d, i;
  logic [11:0] w0;
  sdc_row_t rows [10] = '{
    '{sdc_pkg::CMD_ACT, 2'h1, 12'h005, 4'h2, 1'b0, 1'b0},
    '{sdc_pkg::CMD_WR, 2'h1, 12'h012, 4'h2, 1'b1, 1'b0},
    '{sdc_pkg::CMD_RD, 2'h1, 12'h034, 4'h2, 1'b1, 1'b0},
    '{sdc_pkg::CMD_BST, 2'h1, 12'h000, 4'h2, 1'b0, 1'b0},
    '{sdc_pkg::CMD_PRE, 2'h1, 12'h000, 4'h0, 1'b0, 1'b0},
    '{sdc_pkg::CMD_ACT, 2'h3, 12'h000, 4'h8, 1'b0, 1'b0},
    '{sdc_pkg::CMD_ACT, 2'h2, 12'h000, 4'hC, 1'b0, 1'b0},
    '{sdc_pkg::CMD_PRE, 2'h0, 12'h400, 4'h0, 1'b0, 1'b0},
    '{sdc_pkg::CMD_REF, 2'h0, 12'hFFF, 4'h0, 1'b0, 1'b1},
    '{sdc_pkg::CMD_MRS, 2'h0, 12'h000, 4'h0, 1'b0, 1'b0}};
  sdc_wap_t wap [7] = '{'{1'b0, 1'b1, 1'b0, 4'h3}, '{1'b1, 1'b1, 1'b0, 4'h4},
    '{1'b1, 1'b1, 1'b1, 4'h5}, '{1'b1, 1'b1, 1'b0, 4'h6}, '{1'b1, 1'b0, 1'b0, 4'h4},
    '{1'b0, 1'b0, 1'b0, 4'h3}, '{1'b0, 1'b1, 1'b0, 4'h6}};
  sdc_link_if lnk ();
  sdc_controller u_sdc_controller (.clk(clk), .rst(rst), .link(lnk.ctrl),
    .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr),
    .req_mask(req_mask), .req_cke(req_cke), .req_ready(req_ready));
  sdc_device u_sdc_device (.link(lnk.dev), .rst(rst), .bank_active(bank_active),
    .powered_down(powered_down), .in_self_refresh(in_self_refresh), .clk_gated(clk_gated),
    .refresh_row(refresh_row), .refresh_pulse(refresh_pulse), .column(column),
    .col_auto_precharge(col_auto_precharge), .col_write(col_write), .col_valid(col_valid),
    .illegal_cmd(illegal_cmd));
  sdc_link_monitor u_sdc_link_monitor (.ck(lnk.ck), .rst(rst), .cke(lnk.cke),
    .cs_n(lnk.cs_n), .ras_n(lnk.ras_n), .cas_n(lnk.cas_n), .we_n(lnk.we_n),
    .bank_select(lnk.bank_select), .addr(lnk.addr), .write_data_mask(lnk.write_data_mask));
  // ----------------------------------------
  // Clock, link observation, helpers
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // Pulses last one link cycle, so they are counted rather than polled
  always @(posedge lnk.ck) begin
    lcyc <= lcyc + 1;
    n_col <= n_col + int'(col_valid === 1'b1);
    n_ref <= n_ref + int'(refresh_pulse === 1'b1);
    n_ill <= n_ill + int'(illegal_cmd === 1'b1);
    if (lnk.cs_n === 1'b0 && {lnk.ras_n, lnk.cas_n, lnk.we_n} !== 3'h7) begin
      n_cmd <= n_cmd + 1;
      cmd_cyc <= lcyc;
    end
  end
  task automatic finish_test;
    if (fails == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : finish_test
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic link_wait(input int n);
    repeat (n) @(posedge lnk.ck);
  endtask : link_wait
  task automatic issue(input logic [3:0] c, input logic [1:0] b, input logic [11:0] a,
      input logic m, input logic k);
    int n0;
    int j;
    logic rp;
    n0 = n_cmd;
    j = 0;
    rp = 1'b0;
    @(posedge clk);
    #1;
    req_valid = 1'b1;
    req_cmd = c;
    req_bank = b;
    req_addr = a;
    req_mask = m;
    req_cke = k;
    // Held until the edge that takes it: ready falls only on a take
    while (!(rp === 1'b1 && req_ready === 1'b0)) begin
      rp = req_ready;
      @(posedge clk);
      #1;
      j++;
      if (j > 800) begin
        fails++;
        finish_test();
      end
    end
    req_valid = 1'b0;
    while (k && c[3] == 1'b0 && c != sdc_pkg::CMD_NOP && n_cmd == n0 && j < 900) begin
      @(posedge clk);
      j++;
    end
    if (j >= 900) begin
      fails++;
      finish_test();
    end
  endtask : issue
  function automatic int exp_bad(input bit rd, input bit same, input int dc, input bit m);
    if (dc > 8) return 0;
    if (same && rd) return (dc == 6) ? 0 : ((dc == 4 || dc == 5) ? int'(!m) : 1);
    if (same) return (dc == 3 || dc == 4) ? 0 : 1;
    return rd ? int'(dc < 6) : int'(dc < 3);
  endfunction : exp_bad
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    #400000;
    fails++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_cmd = sdc_pkg::CMD_DESEL;
    req_bank = 2'h0;
    req_addr = 12'h000;
    req_mask = 1'b0;
    req_cke = 1'b0;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;
    link_wait(3);
    check({bank_active, powered_down, in_self_refresh, clk_gated}, 12'h000);
    check(refresh_row, 12'h000);
    issue(sdc_pkg::CMD_DESEL, 2'h0, 12'h000, 1'b0, 1'b1);
    foreach (rows[r]) begin
      i0 = n_ill;
      c0 = n_col;
      f0 = n_ref;
      w0 = refresh_row;
      issue(rows[r].c, rows[r].b, rows[r].a, 1'b0, 1'b1);
      link_wait(4);
      check(12'(bank_active), 12'(rows[r].act));
      check(12'(n_col - c0), 12'(rows[r].col));
      check(12'(n_ref - f0), 12'(rows[r].rf));
      check(12'(n_ill - i0), 12'h000);
      if (rows[r].col) check({col_write, col_auto_precharge, column},
        {rows[r].c == sdc_pkg::CMD_WR, rows[r].a[10:0]});
      if (rows[r].rf) check(refresh_row, w0 + 12'h001);
    end
    // Power-down follows clock enable in both directions
    issue(sdc_pkg::CMD_DESEL, 2'h0, 12'h000, 1'b0, 1'b0);
    link_wait(4);
    check(12'(powered_down), 12'h001);
    issue(sdc_pkg::CMD_DESEL, 2'h0, 12'h000, 1'b0, 1'b1);
    link_wait(4);
    check(12'(powered_down), 12'h000);
    // Self refresh: an activate sent meanwhile must be ignored
    issue(sdc_pkg::CMD_REF, 2'h0, 12'h000, 1'b0, 1'b0);
    link_wait(4);
    check({in_self_refresh, clk_gated, powered_down}, 12'h006);
    i0 = n_ill;
    issue(sdc_pkg::CMD_ACT, 2'h0, 12'h000, 1'b0, 1'b0);
    link_wait(4);
    check({bank_active, 8'(n_ill - i0)}, 12'h000);
    issue(sdc_pkg::CMD_DESEL, 2'h0, 12'h000, 1'b0, 1'b1);
    link_wait(4);
    check({in_self_refresh, clk_gated}, 12'h000);
    // Commands landing inside the write-with-auto-precharge window
    foreach (wap[w]) begin
      issue(sdc_pkg::CMD_PRE, 2'h0, 12'h400, 1'b0, 1'b1);
      issue(sdc_pkg::CMD_ACT, 2'h0, 12'h000, 1'b0, 1'b1);
      issue(sdc_pkg::CMD_ACT, 2'h1, 12'h000, 1'b0, 1'b1);
      issue(sdc_pkg::CMD_WR, 2'h0, 12'h408, 1'b0, 1'b1);
      t0 = cmd_cyc;
      i0 = n_ill;
      i = 0;
      while (lcyc < t0 + int'(wap[w].dd) - 1 && i < 99) begin
        @(posedge lnk.ck);
        i++;
      end
      if (i >= 99) begin
        fails++;
        finish_test();
      end
      issue(wap[w].rd ? sdc_pkg::CMD_RD : sdc_pkg::CMD_WR, {1'b0, !wap[w].same}, 12'h020,
        wap[w].m, 1'b1);
      d = cmd_cyc - t0;
      link_wait(4);
      check(12'(n_ill - i0), 12'(exp_bad(wap[w].rd, wap[w].same, d, wap[w].m)));
      link_wait(10);
      if (w == 0 && (d == 3 || d == 4)) check(12'(bank_active[0]), 12'h001);
    end
    // Mid-run reset: open banks and the refresh counter must drop to zero
    @(posedge clk);
    #1;
    rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    rst = 1'b0;
    link_wait(3);
    check({bank_active, powered_down, in_self_refresh, clk_gated, refresh_row[4:0]}, 12'h000);
    finish_test();
  end
endmodule : sdram_refresh_powerdown_cmd_bench
